// file: sdaq_pkg.sv
/*
 * sdaq_pkg: constants, register map and carrier types of the servo data
 * acquisition sequencer.
 * assumes: a 50 MHz system clock and a 32-bit classic wishbone master.
 */
package sdaq_pkg;

  // --------------------------------------------------------------
  // timing
  // --------------------------------------------------------------
  localparam int CLK_MHZ = 50;
  localparam int SERVO_PERIOD_US = 400;
  localparam int SERVO_CYC = SERVO_PERIOD_US * CLK_MHZ;

  // --------------------------------------------------------------
  // register map, byte offsets
  // --------------------------------------------------------------
  localparam int ADR_W = 6;
  localparam logic [ADR_W-1:0] OFS_SETUP = 6'h00;
  localparam logic [ADR_W-1:0] OFS_RATE = 6'h04;
  localparam logic [ADR_W-1:0] OFS_TARGET = 6'h08;
  localparam logic [ADR_W-1:0] OFS_ARM = 6'h0c;
  localparam logic [ADR_W-1:0] OFS_DONE = 6'h10;
  localparam logic [ADR_W-1:0] OFS_COUNT = 6'h14;
  localparam logic [ADR_W-1:0] OFS_DATA = 6'h18;
  localparam logic [ADR_W-1:0] OFS_IRQ_STAT = 6'h1c;
  localparam logic [ADR_W-1:0] OFS_IRQ_MASK = 6'h20;

  // --------------------------------------------------------------
  // fields
  // --------------------------------------------------------------
  localparam int CHAN_LSB = 0;
  localparam int CHAN_W = 3;
  localparam int MODE_LSB = 4;
  localparam int MODE_W = 2;
  localparam int RATE_W = 10;
  localparam int CNT_W = 10;
  localparam int NUM_CH = 4;
  localparam int IRQ_W = 2;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_SAMPLE = 1;
  localparam logic [MODE_W-1:0] MODE_IMMEDIATE = 2'h0;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;

  // --------------------------------------------------------------
  // types
  // --------------------------------------------------------------
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [ADR_W-1:0] adr;
    logic [31:0] dat;
  } sdaq_wb_req_t;

  typedef struct packed {
    logic [NUM_CH-1:0][31:0] ch;
  } sdaq_fb_pos_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT_TRIG,
    ST_RUN,
    ST_STORE
  } sdaq_state_t;

  // channel select code to channel mask, codes as printed
  function automatic logic [NUM_CH-1:0] sdaq_chan_mask(
      input logic [CHAN_W-1:0] code);
    case (code)
      3'h1: sdaq_chan_mask = 4'h1;
      3'h2: sdaq_chan_mask = 4'h2;
      3'h3: sdaq_chan_mask = 4'h3;
      3'h4: sdaq_chan_mask = 4'h4;
      3'h5: sdaq_chan_mask = 4'h5;
      3'h6: sdaq_chan_mask = 4'ha;
      3'h7: sdaq_chan_mask = 4'h7;
      default: sdaq_chan_mask = 4'h0;
    endcase
  endfunction : sdaq_chan_mask

  // byte-lane merge of a wishbone write
  function automatic logic [31:0] sdaq_merge(input logic [31:0] old,
      input logic [31:0] wdat, input logic [3:0] sel);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    sdaq_merge = (old & ~m) | (wdat & m);
  endfunction : sdaq_merge

endpackage : sdaq_pkg

// file: sdaq_top.sv
/*
 * sdaq_top: servo data acquisition sequencer with a classic wishbone
 * register slave, flip-flop sample store and one level interrupt.
 * assumes: feedback positions and trigger are synchronous to CLK_SYS_I;
 * the servo tick is generated here from the system clock.
 */
// How it works
// - channel select code picks captured feedback channels, codes as printed.
// - one sample every rate plus one servo cycles of 400 us.
// - done only when collected samples equal the programmed count.
// - done query reads 1 when complete, 0 otherwise.
// - host fetches after done; device then returns stored words.
// - each sample carries the running servo tick count.
// - arm flag 1 arms the acquisition, 0 disarms it.
// - count query returns samples so far, also while running.
// - mode zero starts on arming; other modes wait for trigger.
// - fetched data are 32-bit words, length set by setup.
`timescale 1ns/1ns
module sdaq_top #(
  parameter int SERVO_CYCLES = sdaq_pkg::SERVO_CYC,
  parameter int DEPTH = 64
) (
  // clock and reset
  input wire logic CLK_SYS_I,
  input wire logic NRST_I,
  // wishbone slave
  input wire sdaq_pkg::sdaq_wb_req_t WB_REQ_I,
  output logic WB_ACK_O,
  output logic [31:0] WB_DAT_O,
  // feedback and trigger
  input wire sdaq_pkg::sdaq_fb_pos_t FB_POS_I,
  input wire logic TRIG_I,
  // interrupt
  output logic IRQ_O
);
  import sdaq_pkg::*;

  localparam int PTR_W = $clog2(DEPTH) + 1;
  localparam int DIV_W = $clog2(SERVO_CYCLES);

  if (DEPTH < 2 || SERVO_CYCLES <= NUM_CH + 2) begin : g_chk
    $error("sdaq_top: DEPTH or SERVO_CYCLES too small");
  end

  // --------------------------------------------------------------
  // registers
  // --------------------------------------------------------------
  logic ack_r;
  logic [31:0] rdat_r;
  logic irq_r;
  logic [31:0] setup_r;
  logic [RATE_W-1:0] rate_r;
  logic [CNT_W-1:0] target_r;
  logic armed_r;
  logic done_r, done_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic [IRQ_W-1:0] stat_r, stat_nxt;
  logic [IRQ_W-1:0] mask_r;
  sdaq_state_t st_r, st_nxt;
  logic [RATE_W-1:0] div_r, div_nxt;
  logic [2:0] idx_r, idx_nxt;
  logic [PTR_W-1:0] wr_ptr_r, wr_ptr_nxt;
  logic [PTR_W-1:0] rd_ptr_r, rd_ptr_nxt;
  logic [DIV_W-1:0] pre_r;
  logic tick_r;
  logic [31:0] tick_cnt_r;
  logic [31:0] snap_tick_r;
  sdaq_fb_pos_t snap_pos_r;
  logic [31:0] mem_r [DEPTH];

  // --------------------------------------------------------------
  // bus decode
  // --------------------------------------------------------------
  wire acc = WB_REQ_I.cyc & WB_REQ_I.stb & ~ack_r;
  wire wr = acc & WB_REQ_I.we;
  wire rd = acc & ~WB_REQ_I.we;
  wire [ADR_W-1:0] adr = WB_REQ_I.adr;
  wire [31:0] wdat = WB_REQ_I.dat;
  wire [3:0] sel = WB_REQ_I.sel;
  wire wr_setup = wr & (adr == OFS_SETUP);
  wire wr_rate = wr & (adr == OFS_RATE);
  wire wr_target = wr & (adr == OFS_TARGET);
  wire wr_arm = wr & (adr == OFS_ARM) & sel[0];
  wire wr_data = wr & (adr == OFS_DATA);
  wire wr_stat = wr & (adr == OFS_IRQ_STAT) & sel[0];
  wire wr_mask = wr & (adr == OFS_IRQ_MASK);
  wire rd_data = rd & (adr == OFS_DATA);
  wire arm_on = wr_arm & wdat[0];
  wire [31:0] setup_w = sdaq_merge(setup_r, wdat, sel);
  wire [31:0] rate_w = sdaq_merge({{(32-RATE_W){1'b0}}, rate_r}, wdat, sel);
  wire [31:0] target_w = sdaq_merge({{(32-CNT_W){1'b0}}, target_r}, wdat,
                                    sel);
  wire [31:0] mask_w = sdaq_merge({{(32-IRQ_W){1'b0}}, mask_r}, wdat, sel);

  // --------------------------------------------------------------
  // configuration fields
  // --------------------------------------------------------------
  wire [CHAN_W-1:0] chan_sel = setup_r[CHAN_LSB +: CHAN_W];
  wire [MODE_W-1:0] mode = setup_r[MODE_LSB +: MODE_W];
  wire [NUM_CH-1:0] ch_mask = sdaq_chan_mask(chan_sel);
  wire target_zero = (target_r == '0);
  wire [CNT_W-1:0] cnt_inc = cnt_r + 1'b1;

  // --------------------------------------------------------------
  // store path
  // --------------------------------------------------------------
  wire [1:0] ch_idx = 2'(idx_r - 3'h1);
  wire word_sel = (idx_r == '0) | ch_mask[ch_idx];
  wire [31:0] word = (idx_r == '0) ? snap_tick_r
                                   : snap_pos_r.ch[ch_idx];
  wire full = (wr_ptr_r == PTR_W'(DEPTH));
  wire mem_we = (st_r == ST_STORE) & word_sel & ~full & ~arm_on;
  wire last_word = (idx_r == 3'(NUM_CH));
  wire [PTR_W-2:0] wr_adr = wr_ptr_r[PTR_W-2:0];
  wire [PTR_W-2:0] rd_adr = rd_ptr_r[PTR_W-2:0];
  wire have_word = (rd_ptr_r < wr_ptr_r);
  wire sample_now = tick_r & (div_r == rate_r);
  wire trig_start = tick_r & TRIG_I;
  wire take = armed_r & ~arm_on & (((st_r == ST_RUN) & sample_now) |
              ((st_r == ST_WAIT_TRIG) & trig_start));

  // --------------------------------------------------------------
  // sequencer
  // --------------------------------------------------------------
  logic ev_done, ev_smp;
  always_comb begin
    st_nxt = st_r;
    div_nxt = div_r;
    idx_nxt = idx_r;
    cnt_nxt = cnt_r;
    done_nxt = done_r;
    wr_ptr_nxt = wr_ptr_r;
    ev_done = 1'b0;
    ev_smp = 1'b0;
    if (arm_on) begin
      // a fresh arm starts a new request
      cnt_nxt = '0;
      wr_ptr_nxt = '0;
      div_nxt = '0;
      idx_nxt = '0;
      done_nxt = target_zero;
      ev_done = target_zero;
      if (target_zero) begin
        st_nxt = ST_IDLE;
      end else if (mode == MODE_IMMEDIATE) begin
        st_nxt = ST_RUN;
      end else begin
        st_nxt = ST_WAIT_TRIG;
      end
    end else begin
      unique case (st_r)
        ST_IDLE: begin
        end
        ST_WAIT_TRIG, ST_RUN: begin
          if (!armed_r) begin
            st_nxt = ST_IDLE;
          end else if (take) begin
            st_nxt = ST_STORE;
            div_nxt = '0;
          end else if (tick_r && st_r == ST_RUN) begin
            div_nxt = div_r + 1'b1;
          end
        end
        ST_STORE: begin
          if (mem_we) begin
            wr_ptr_nxt = wr_ptr_r + 1'b1;
          end
          if (last_word) begin
            idx_nxt = '0;
            cnt_nxt = cnt_inc;
            ev_smp = 1'b1;
            if (cnt_inc == target_r) begin
              done_nxt = 1'b1;
              ev_done = 1'b1;
              st_nxt = ST_IDLE;
            end else begin
              st_nxt = ST_RUN;
            end
          end else begin
            idx_nxt = idx_r + 1'b1;
          end
        end
      endcase
    end
  end

  // --------------------------------------------------------------
  // read pointer and read mux
  // --------------------------------------------------------------
  assign rd_ptr_nxt = (arm_on | wr_data) ? '0 :
                      (rd_data & have_word) ? rd_ptr_r + 1'b1 : rd_ptr_r;
  wire [31:0] rd_mux =
      (adr == OFS_SETUP) ? setup_r :
      (adr == OFS_RATE) ? {{(32-RATE_W){1'b0}}, rate_r} :
      (adr == OFS_TARGET) ? {{(32-CNT_W){1'b0}}, target_r} :
      (adr == OFS_ARM) ? {31'h0, armed_r} :
      (adr == OFS_DONE) ? {31'h0, done_r} :
      (adr == OFS_COUNT) ? {{(32-CNT_W){1'b0}}, cnt_r} :
      (adr == OFS_DATA) ? (have_word ? mem_r[rd_adr] : RD_ZERO) :
      (adr == OFS_IRQ_STAT) ? {{(32-IRQ_W){1'b0}}, stat_r} :
      (adr == OFS_IRQ_MASK) ? {{(32-IRQ_W){1'b0}}, mask_r} : RD_ZERO;

  // set wins over a write-one clear in the same cycle
  wire [IRQ_W-1:0] ev_vec = {ev_smp, ev_done};
  wire [IRQ_W-1:0] clr_vec = wr_stat ? wdat[IRQ_W-1:0] : '0;
  assign stat_nxt = (stat_r & ~clr_vec) | ev_vec;

  // --------------------------------------------------------------
  // servo tick and tick counter
  // --------------------------------------------------------------
  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      pre_r <= '0;
      tick_r <= 1'b0;
      tick_cnt_r <= '0;
    end else begin
      tick_r <= (pre_r == DIV_W'(SERVO_CYCLES - 1));
      pre_r <= (pre_r == DIV_W'(SERVO_CYCLES - 1)) ? '0 : pre_r + 1'b1;
      if (tick_r) begin
        tick_cnt_r <= tick_cnt_r + 1'b1;
      end
    end
  end

  // --------------------------------------------------------------
  // control state
  // --------------------------------------------------------------
  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      st_r <= ST_IDLE;
      div_r <= '0;
      idx_r <= '0;
      cnt_r <= '0;
      done_r <= 1'b0;
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      stat_r <= '0;
    end else begin
      st_r <= st_nxt;
      div_r <= div_nxt;
      idx_r <= idx_nxt;
      cnt_r <= cnt_nxt;
      done_r <= done_nxt;
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      stat_r <= stat_nxt;
    end
  end

  // --------------------------------------------------------------
  // software registers
  // --------------------------------------------------------------
  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      setup_r <= '0;
      rate_r <= '0;
      target_r <= '0;
      mask_r <= '0;
      armed_r <= 1'b0;
    end else begin
      if (wr_setup) setup_r <= setup_w;
      if (wr_rate) rate_r <= rate_w[RATE_W-1:0];
      if (wr_target) target_r <= target_w[CNT_W-1:0];
      if (wr_mask) mask_r <= mask_w[IRQ_W-1:0];
      if (wr_arm) armed_r <= wdat[0];
    end
  end

  // --------------------------------------------------------------
  // bus answer and interrupt
  // --------------------------------------------------------------
  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      ack_r <= 1'b0;
      rdat_r <= '0;
      irq_r <= 1'b0;
    end else begin
      ack_r <= acc;
      rdat_r <= rd ? rd_mux : RD_ZERO;
      irq_r <= |(stat_nxt & mask_r);
    end
  end

  // --------------------------------------------------------------
  // snapshot and sample store, no reset: data only
  // --------------------------------------------------------------
  always_ff @(posedge CLK_SYS_I) begin
    if (take) begin
      snap_tick_r <= tick_cnt_r;
      snap_pos_r <= FB_POS_I;
    end
    if (mem_we) begin
      mem_r[wr_adr] <= word;
    end
  end

  assign WB_ACK_O = ack_r;
  assign WB_DAT_O = rdat_r;
  assign IRQ_O = irq_r;

endmodule : sdaq_top

// file: sdaq_top_props.sv
/*
 * sdaq_top_props: port-level checks of the acquisition sequencer.
 * assumes: one clock domain, bus master holds requests until ack.
 */
`timescale 1ns/1ns
module sdaq_top_props
  import sdaq_pkg::*;
(
  // clock and reset
  input wire logic CLK_SYS_I,
  input wire logic NRST_I,
  // bus, feedback, trigger, interrupt
  input wire sdaq_pkg::sdaq_wb_req_t WB_REQ_I,
  input wire logic WB_ACK_O,
  input wire logic [31:0] WB_DAT_O,
  input wire sdaq_pkg::sdaq_fb_pos_t FB_POS_I,
  input wire logic TRIG_I,
  input wire logic IRQ_O
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  wire req = WB_REQ_I.cyc & WB_REQ_I.stb;
  wire rd_ack = WB_ACK_O & ~WB_REQ_I.we;
  wire [5:0] adr = WB_REQ_I.adr;
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (!NRST_I);
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_ack_one_wait: assert property (req && !WB_ACK_O |=> WB_ACK_O)
    else $error("ack late");
  a_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack longer than one cycle");
  a_dat_idle: assert property (!WB_ACK_O |-> WB_DAT_O == RD_ZERO)
    else $error("read data outside ack");
  a_done_flag: assert property (
    rd_ack && adr == OFS_DONE |-> WB_DAT_O[31:1] == 31'h0)
    else $error("done word not 0 or 1");
  a_count_range: assert property (
    rd_ack && adr == OFS_COUNT |-> WB_DAT_O[31:CNT_W] == 22'h0)
    else $error("count wider than field");
  a_unmapped_zero: assert property (
    rd_ack && adr >= 6'h24 |-> WB_DAT_O == RD_ZERO)
    else $error("unmapped read not zero");
  a_mask_quiet: assert property (WB_ACK_O && WB_REQ_I.we &&
    adr == OFS_IRQ_MASK && WB_REQ_I.sel[0] && WB_REQ_I.dat[1:0] == 2'h0
    |-> ##2 !IRQ_O)
    else $error("irq with all masked");
  a_reset_quiet: assert property ($rose(NRST_I) |-> !WB_ACK_O && !IRQ_O)
    else $error("outputs busy after reset");
  c_done_seen: cover property (rd_ack && adr == OFS_DONE && WB_DAT_O[0]);
  c_irq_seen: cover property (IRQ_O);
  c_trig_seen: cover property (TRIG_I && req);
endmodule : sdaq_top_props

bind sdaq_top sdaq_top_props i_props (.CLK_SYS_I(CLK_SYS_I),
  .NRST_I(NRST_I), .WB_REQ_I(WB_REQ_I), .WB_ACK_O(WB_ACK_O),
  .WB_DAT_O(WB_DAT_O), .FB_POS_I(FB_POS_I), .TRIG_I(TRIG_I),
  .IRQ_O(IRQ_O));

// file: sdaq_fb_model.sv
/*
 * sdaq_fb_model: position feedback source, axes at rest.
 * assumes: nothing; positions are constant so words are predictable.
 */
`timescale 1ns/1ns
module sdaq_fb_model
  import sdaq_pkg::*;
(
  // feedback out
  output sdaq_pkg::sdaq_fb_pos_t fb_o
);
  // axes never home or seek limit or index, so arming is always legal
  assign fb_o.ch = {32'h44444444, 32'h33333333, 32'h22222222,
    32'h11111111};
endmodule : sdaq_fb_model

// file: sdaq_top_tb.sv
/*
 * sdaq_top_tb: self-checking bench of the acquisition sequencer.
 * assumes: short servo tick (16 clocks) so runs stay brief.
 */
`timescale 1ns/1ns
module sdaq_top_tb;
  import sdaq_pkg::*;
  localparam int SC = 16;
  logic clk = 0, nrst_n = 0, trig = 0, ack, irq;
  logic [31:0] rdat;
  sdaq_wb_req_t req = '0;
  sdaq_fb_pos_t fb;
  int fail_count = 0, samples_checked = 0;
  // ----------------------------------------------------------------
  // design and feedback source
  // ----------------------------------------------------------------
  sdaq_top #(.SERVO_CYCLES(SC)) i_dut (.CLK_SYS_I(clk), .NRST_I(nrst_n),
    .WB_REQ_I(req), .WB_ACK_O(ack), .WB_DAT_O(rdat), .FB_POS_I(fb),
    .TRIG_I(trig), .IRQ_O(irq));
  sdaq_fb_model i_fb (.fb_o(fb));
  initial forever #10 clk = ~clk;
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task check(input string n, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s exp %h seen %h", n, exp, seen);
    end
  endtask : check
  task xfer(input logic w, input logic [5:0] a, input logic [31:0] wd,
      output logic [31:0] d);
    @(posedge clk);
    req <= '{1'b1, 1'b1, w, 4'hf, a, wd};
    do @(posedge clk); while (ack !== 1'b1);
    d = rdat;
    req <= '0;
  endtask : xfer
  task wr(input logic [5:0] a, input logic [31:0] wd);
    logic [31:0] d;
    xfer(1'b1, a, wd, d);
  endtask : wr
  task rd_chk(input string n, input logic [5:0] a, input logic [31:0] e);
    logic [31:0] d;
    xfer(1'b0, a, 32'h0, d);
    check(n, d, e);
  endtask : rd_chk
  task start(input logic [5:0] s, input logic [9:0] r, t);
    wr(OFS_SETUP, {26'h0, s});
    wr(OFS_RATE, {22'h0, r});
    wr(OFS_TARGET, {22'h0, t});
    wr(OFS_ARM, 32'h1);
  endtask : start
  // host polls done before fetching
  task wait_done;
    logic [31:0] d;
    for (int i = 0; i < 300; i++) begin
      xfer(1'b0, OFS_DONE, 32'h0, d);
      if (d[0] === 1'b1) break;
    end
    check("done reached", d, 32'h1);
  endtask : wait_done
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task basic_run;
    logic [31:0] t[3];
    start(6'h03, 10'h1, 10'h3);
    rd_chk("done early", OFS_DONE, 32'h0);
    repeat (2 * SC) @(posedge clk);
    rd_chk("count running", OFS_COUNT, 32'h1);
    wait_done;
    rd_chk("count", OFS_COUNT, 32'h3);
    check("irq set", {31'h0, irq}, 32'h1);
    for (int i = 0; i < 3; i++) begin
      xfer(1'b0, OFS_DATA, 32'h0, t[i]);
      rd_chk("ch1", OFS_DATA, 32'h11111111);
      rd_chk("ch2", OFS_DATA, 32'h22222222);
    end
    check("tick step a", t[1] - t[0], 32'h2);
    check("tick step b", t[2] - t[1], 32'h2);
    rd_chk("unmapped", 6'h3c, 32'h0);
    wr(OFS_IRQ_STAT, 32'h1);
    repeat (2) @(posedge clk);
    check("irq cleared", {31'h0, irq}, 32'h0);
    // sample event still pending: unmask it, then mask everything
    wr(OFS_IRQ_MASK, 32'h2);
    repeat (2) @(posedge clk);
    check("irq sample", {31'h0, irq}, 32'h1);
    wr(OFS_IRQ_MASK, 32'h0);
    repeat (2) @(posedge clk);
    check("irq masked", {31'h0, irq}, 32'h0);
    wr(OFS_IRQ_MASK, 32'h1);
  endtask : basic_run
  task chan_codes;
    logic [3:0] m[8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'ha, 4'h7};
    logic [31:0] d;
    for (int c = 0; c < 8; c++) begin
      start(c[5:0], 10'h0, 10'h1);
      wait_done;
      xfer(1'b0, OFS_DATA, 32'h0, d);
      for (int k = 0; k < 4; k++)
        if (m[c][k]) rd_chk("chan", OFS_DATA, 32'h11111111 * (k + 1));
      rd_chk("length", OFS_DATA, 32'h0);
    end
  endtask : chan_codes
  task trig_disarm;
    logic [31:0] c;
    start(6'h11, 10'h0, 10'h8);
    repeat (3 * SC) @(posedge clk);
    rd_chk("no trigger", OFS_COUNT, 32'h0);
    trig <= 1'b1;
    repeat (3 * SC) @(posedge clk);
    wr(OFS_ARM, 32'h0);
    repeat (8) @(posedge clk);
    xfer(1'b0, OFS_COUNT, 32'h0, c);
    repeat (3 * SC) @(posedge clk);
    rd_chk("stopped", OFS_COUNT, c);
    rd_chk("not done", OFS_DONE, 32'h0);
    check("started", {31'h0, c != 0}, 32'h1);
    xfer(1'b0, OFS_DATA, 32'h0, c);
    rd_chk("kept", OFS_DATA, 32'h11111111);
    // trigger still high: the other trigger modes start at once
    for (int md = 2; md < 4; md++) begin
      start({md[1:0], 4'h1}, 10'h0, 10'h1);
      wait_done;
      rd_chk("trig mode", OFS_COUNT, 32'h1);
    end
  endtask : trig_disarm
  task complete_run;
    if (fail_count == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : complete_run
  initial begin
    repeat (20) @(posedge clk);
    nrst_n <= 1'b1;
    wr(OFS_IRQ_MASK, 32'h1);
    basic_run;
    chan_codes;
    trig_disarm;
    complete_run;
  end
  initial begin
    repeat (40000) @(posedge clk);
    fail_count++;
    complete_run;
  end
endmodule : sdaq_top_tb
